// >>> evfp_tagging_negotiation.sv
// Virtual fabric tagging negotiator with APB register access
// Contract
// - FEF is control identifier, marks control traffic
// - Unique transaction id; sync then commit phase
// - Initiator opens with sync carrying own parameters
// - Initiator accepts tagged frames on sending sync
// - Responder accepts sync with own parameters, decides
// - Responder untagged: mismatch isolates, match relogins
// - Initiator decides on acceptance; untagged stops accepting
// - Initiator untagged: mismatch isolates, match relogins
// - Responder enables operational, control, initiator identifiers
// - Responder commit tagged with initiator port identifier
// - Initiator on commit enables same identifier set
// - Initiator accepts commit tagged with own identifier
// - Success only after commit exchange completes
// - Drop initiator identifier if not operational
// - Each operational fabric starts its own login
// - Empty operational set stays in negotiation; the code still pulses success, returns to idle and starts no login
// - Collision: node stays initiator, fabric responds
// - Remaining initiator rejects sync with collision reason
// - New responder answers, aborts own on reject
// - Untagged link uses port id, tagging uses control
// - Configuration change reruns the negotiation
// - Isolated state holds port offline until reconfigured; the code still answers a received sync while isolated
// - Holds admin status, port identifier, enabled list
`timescale 1ns/1ns
`include "evfp_defines.svh"
module evfp_tagging_negotiation
  import evfp_pkg::*;
#(
  parameter int N_VF = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [63:0] core_name,
  output logic tx_valid,
  input wire logic tx_ready,
  output msg_kind_type tx_kind,
  output logic [`TID_W-1:0] tx_tid,
  output logic tx_tagged,
  output logic [11:0] tx_tag_vfid,
  output logic [63:0] tx_name,
  output logic [1:0] tx_admin,
  output logic [11:0] tx_port_vfid,
  output logic [N_VF*12-1:0] tx_list,
  output logic [7:0] tx_reason,
  input wire logic rx_valid,
  input wire msg_kind_type rx_kind,
  input wire logic [`TID_W-1:0] rx_tid,
  input wire logic rx_tagged,
  input wire logic [11:0] rx_tag_vfid,
  input wire logic [1:0] rx_admin,
  input wire logic [11:0] rx_port_vfid,
  input wire logic [N_VF*12-1:0] rx_list,
  output logic rx_ctrl,
  output logic [1:0] peer_admin,
  output logic [11:0] peer_port_vfid,
  output logic [N_VF*12-1:0] peer_list,
  input wire logic dec_adopt,
  input wire logic [N_VF-1:0] dec_oper,
  output logic rx_tag_accept,
  output logic tag_ctrl_en,
  output logic [N_VF-1:0] tag_vf_en,
  output logic tag_pid_en,
  output logic [11:0] tag_pid_vfid,
  output logic go_login,
  output logic isolated,
  output logic [N_VF-1:0] vf_login_start,
  output logic success
);

  if (N_VF < 1 || N_VF > 8) begin : g_check
    $error("N_VF must be between 1 and 8");
  end

  state_type st;
  logic [1:0] admin;
  logic [11:0] port_vfid;
  logic node_role;
  logic [N_VF*12-1:0] en_list;
  logic start_pend;
  logic [`TID_W-1:0] tid;
  logic [`TID_W-1:0] peer_tid;
  logic [N_VF-1:0] oper;
  logic col_wait;
  logic done_ok;

  // APB decode; answer in the first access cycle
  wire wr_en = ce && psel && penable && pwrite;
  wire setup = ce && psel && !penable;
  wire [4:0] list_idx = paddr[6:2] - 5'h04;
  wire list_hit = paddr[11:7] == 5'h00 && paddr[6:2] >= 5'h04 && list_idx < 5'(N_VF) && paddr[1:0] == 2'h0;
  wire hit_ctrl = paddr == `OFS_CTRL;
  wire hit_port = paddr == `OFS_PORT;
  wire hit_stat = paddr == `OFS_STATUS;
  wire mapped = hit_ctrl || hit_port || hit_stat || list_hit;
  wire cfg_wr = wr_en && mapped && !hit_stat;
  assign pready = penable;
  assign pslverr = psel && penable && !mapped;

  // Message events
  wire tx_fire = ce && tx_valid && tx_ready;
  wire rx_hit = ce && rx_valid && rx_tid == tid;
  wire rx_sync = ce && rx_valid && rx_kind == MSG_SYNC;
  wire tagging = tag_ctrl_en;
  wire pid_match = peer_port_vfid == port_vfid;
  wire i_decide = ce && st == ST_I_DEC;
  wire r_acc_done = st == ST_R_ACC && tx_fire;
  wire i_commit_rx = st == ST_I_WCOMMIT && rx_hit && rx_kind == MSG_COMMIT && rx_tagged && rx_tag_vfid == port_vfid;
  wire r_finish = st == ST_R_WCACC && rx_hit && rx_kind == MSG_ACC;
  wire i_finish = st == ST_I_CACC && tx_fire;
  wire finish_now = r_finish || i_finish;
  wire no_tag = (i_decide || r_acc_done) && !dec_adopt;
  wire collide = st == ST_I_WACC && rx_sync;
  assign rx_ctrl = rx_valid && rx_tagged && rx_tag_vfid == `CTRL_VFID;

  // Initiator port identifier lies in the operational set
  logic pid_in_op;
  always_comb begin
    pid_in_op = 1'b0;
    for (int i = 0; i < N_VF; i++) begin
      if (oper[i] && en_list[i*12 +: 12] == tag_pid_vfid) pid_in_op = 1'b1;
    end
  end

  // Configuration registers; any change restarts negotiation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      admin <= `RST_ADMIN;
      port_vfid <= `RST_PORT_VFID;
      node_role <= `RST_NODE;
      en_list <= '0;
      start_pend <= 1'b0;
    end else if (ce) begin
      if (wr_en && hit_ctrl) begin
        admin <= pwdata[`CTRL_ADMIN_LSB +: 2];
        node_role <= pwdata[`CTRL_NODE_BIT];
      end
      if (wr_en && hit_port) port_vfid <= pwdata[11:0];
      if (wr_en && list_hit) en_list[list_idx*12 +: 12] <= pwdata[11:0];
      if (cfg_wr || (wr_en && hit_ctrl && pwdata[`CTRL_START_BIT])) start_pend <= 1'b1;
      else if (st == ST_IDLE) start_pend <= 1'b0;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= '0;
    else if (setup) begin
      prdata <= '0;
      if (hit_ctrl) prdata <= {28'h0, node_role, admin, 1'b0};
      if (hit_port) prdata <= {20'h0, port_vfid};
      if (hit_stat) prdata <= {16'h0, 8'(oper), 2'h0, tag_pid_en, col_wait, done_ok, isolated, tagging, st != ST_IDLE};
      if (list_hit) prdata <= {20'h0, en_list[list_idx*12 +: 12]};
    end
  end

  // Payload of every outgoing message is our own configuration
  assign tx_valid = st == ST_I_SYNC || st == ST_I_CACC || st == ST_R_ACC || st == ST_R_COMMIT || st == ST_COL_RJT;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_name <= '0;
      tx_admin <= '0;
      tx_port_vfid <= '0;
      tx_list <= '0;
    end else if (ce) begin
      tx_name <= core_name;
      tx_admin <= admin;
      tx_port_vfid <= port_vfid;
      tx_list <= en_list;
    end
  end

  // Negotiation sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ST_IDLE;
      tid <= '0;
      peer_tid <= '0;
      tx_kind <= MSG_SYNC;
      tx_tid <= '0;
      tx_tagged <= 1'b0;
      tx_tag_vfid <= '0;
      tx_reason <= '0;
      col_wait <= 1'b0;
      peer_admin <= '0;
      peer_port_vfid <= '0;
      peer_list <= '0;
    end else if (ce) begin
      if (rx_sync && (st == ST_IDLE || collide)) begin
        peer_tid <= rx_tid;
        peer_admin <= rx_admin;
        peer_port_vfid <= rx_port_vfid;
        peer_list <= rx_list;
      end
      if (st == ST_I_WACC && rx_hit && rx_kind == MSG_ACC) begin
        peer_admin <= rx_admin;
        peer_port_vfid <= rx_port_vfid;
        peer_list <= rx_list;
      end
      if (col_wait && rx_hit && rx_kind == MSG_RJT) col_wait <= 1'b0;
      unique case (st)
        ST_IDLE: begin
          if (rx_sync) begin
            st <= ST_R_ACC;
            tx_kind <= MSG_ACC;
            tx_tid <= rx_tid;
          end else if (start_pend) begin
            st <= ST_I_SYNC;
            tid <= tid + 1'b1;
            tx_kind <= MSG_SYNC;
            tx_tid <= tid + 1'b1;
          end
          tx_tagged <= 1'b1;
          tx_tag_vfid <= tagging ? `CTRL_VFID : port_vfid;
        end
        ST_I_SYNC: if (tx_fire) st <= ST_I_WACC;
        ST_I_WACC: begin
          if (rx_sync && node_role) begin
            st <= ST_COL_RJT;
            tx_kind <= MSG_RJT;
            tx_tid <= rx_tid;
            tx_reason <= `RJT_COLLISION;
          end else if (rx_sync) begin
            st <= ST_R_ACC;
            col_wait <= 1'b1;
            tx_kind <= MSG_ACC;
            tx_tid <= rx_tid;
          end else if (rx_hit && rx_kind == MSG_ACC) st <= ST_I_DEC;
          else if (rx_hit && rx_kind == MSG_RJT) st <= ST_IDLE;
        end
        ST_COL_RJT: if (tx_fire) st <= ST_I_WACC;
        ST_I_DEC: st <= dec_adopt ? ST_I_WCOMMIT : ST_IDLE;
        ST_I_WCOMMIT: begin
          if (i_commit_rx) begin
            st <= ST_I_CACC;
            tx_kind <= MSG_ACC;
            tx_tid <= rx_tid;
            tx_tag_vfid <= port_vfid;
          end
        end
        ST_I_CACC: if (tx_fire) st <= ST_IDLE;
        ST_R_ACC: begin
          if (tx_fire && dec_adopt) begin
            st <= ST_R_COMMIT;
            tx_kind <= MSG_COMMIT;
            tx_tid <= peer_tid;
            tx_tag_vfid <= peer_port_vfid;
          end else if (tx_fire) st <= ST_IDLE;
        end
        ST_R_COMMIT: if (tx_fire) st <= ST_R_WCACC;
        ST_R_WCACC: if (ce && rx_valid && rx_tid == peer_tid && rx_kind == MSG_ACC) st <= ST_IDLE;
      endcase
      if (st == ST_R_ACC && tx_fire) tid <= peer_tid;
    end
  end

  // Tagging enables, operational set and outcome
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_tag_accept <= 1'b0;
      tag_ctrl_en <= 1'b0;
      tag_vf_en <= '0;
      tag_pid_en <= 1'b0;
      tag_pid_vfid <= '0;
      oper <= '0;
      go_login <= 1'b0;
      isolated <= 1'b0;
      vf_login_start <= '0;
      success <= 1'b0;
      done_ok <= 1'b0;
    end else if (ce) begin
      go_login <= 1'b0;
      vf_login_start <= '0;
      success <= 1'b0;
      if (st == ST_I_SYNC && tx_fire) begin
        rx_tag_accept <= 1'b1;
        isolated <= 1'b0;
        done_ok <= 1'b0;
      end
      if ((i_decide || r_acc_done) && dec_adopt) oper <= dec_oper;
      if (r_acc_done && dec_adopt) begin
        tag_ctrl_en <= 1'b1;
        tag_vf_en <= dec_oper;
        tag_pid_en <= 1'b1;
        tag_pid_vfid <= peer_port_vfid;
        rx_tag_accept <= 1'b1;
      end
      if (i_commit_rx) begin
        tag_ctrl_en <= 1'b1;
        tag_vf_en <= oper;
        tag_pid_en <= 1'b1;
        tag_pid_vfid <= port_vfid;
      end
      if (no_tag) begin
        rx_tag_accept <= 1'b0;
        tag_ctrl_en <= 1'b0;
        tag_vf_en <= '0;
        tag_pid_en <= 1'b0;
        isolated <= !pid_match;
        go_login <= pid_match;
      end
      if (finish_now) begin
        success <= 1'b1;
        done_ok <= 1'b1;
        if (!pid_in_op) tag_pid_en <= 1'b0;
        vf_login_start <= oper;
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sync_ctrl_tag_a: assert property (tx_valid && tx_kind == MSG_SYNC && tagging |-> tx_tag_vfid == `CTRL_VFID)
    else $error("sync on tagging link not tagged with control id");
  acc_tid_echo_a: assert property (ce && st == ST_IDLE && rx_sync |=> tx_valid && tx_kind == MSG_ACC && tx_tid == $past(rx_tid))
    else $error("acceptance does not echo transaction id");
  sync_rx_accept_a: assert property (st == ST_I_SYNC && tx_fire |=> rx_tag_accept)
    else $error("tagged reception not enabled after sync");
  commit_tag_a: assert property (tx_valid && tx_kind == MSG_COMMIT |-> tx_tagged && tx_tag_vfid == peer_port_vfid)
    else $error("commit not tagged with initiator port id");
  commit_acc_tag_a: assert property (st == ST_I_CACC |-> tx_kind == MSG_ACC && tx_tag_vfid == port_vfid)
    else $error("commit acceptance not tagged with own port id");
  resp_enable_a: assert property (r_acc_done && dec_adopt |=> tag_ctrl_en && tag_pid_en ##1 st == ST_R_COMMIT)
    else $error("responder did not enable tagging before commit");
  untag_outcome_a: assert property (no_tag |=> isolated != go_login && isolated == ($past(peer_port_vfid) != port_vfid))
    else $error("untagged outcome does not follow port id compare");
  commit_success_a: assert property (finish_now |=> success && done_ok ##1 !success)
    else $error("success not a single pulse after commit exchange");
  pid_drop_a: assert property (finish_now && !pid_in_op |=> !tag_pid_en)
    else $error("initiator port id still enabled outside operational set");
  collision_rjt_a: assert property (ce && collide && node_role |=> tx_valid && tx_kind == MSG_RJT && tx_reason == `RJT_COLLISION)
    else $error("node port did not reject colliding sync");

endmodule // evfp_tagging_negotiation

// >>> evfp_defines.svh
// Register offsets, field positions, reset values and protocol constants of the tagging negotiator
`ifndef EVFP_DEFINES_SVH
`define EVFP_DEFINES_SVH
`define CTRL_VFID 12'hFEF
`define OFS_CTRL 12'h000
`define OFS_PORT 12'h004
`define OFS_STATUS 12'h008
`define OFS_LIST 12'h010
`define CTRL_START_BIT 0
`define CTRL_ADMIN_LSB 1
`define CTRL_NODE_BIT 3
`define RST_ADMIN 2'h0
`define RST_PORT_VFID 12'h001
`define RST_NODE 1'b1
`define RJT_COLLISION 8'h01
`define TID_W 8
`endif

// >>> evfp_pkg.sv
// Types shared by the tagging negotiator
package evfp_pkg;
  typedef enum logic [1:0] {MSG_SYNC, MSG_ACC, MSG_COMMIT, MSG_RJT} msg_kind_type;
  typedef enum logic [3:0] {ST_IDLE, ST_I_SYNC, ST_I_WACC, ST_I_DEC, ST_I_WCOMMIT, ST_I_CACC,
                            ST_R_ACC, ST_R_COMMIT, ST_R_WCACC, ST_COL_RJT} state_type;
endpackage

// >>> evfp_peer_model.sv
// Behavioural link partner that answers a sync and may follow with a tagged commit
`timescale 1ns/1ns
`include "evfp_defines.svh"
module evfp_peer_model
  import evfp_pkg::*;
#(
  parameter int N_VF = 4
) (
  input wire logic pclk,
  input wire logic stall,
  input wire logic [3:0] delay,
  input wire logic do_commit,
  input wire logic [11:0] peer_pid,
  input wire logic tx_valid,
  input wire msg_kind_type tx_kind,
  input wire logic [`TID_W-1:0] tx_tid,
  input wire logic [11:0] tx_tag_vfid,
  input wire logic [11:0] tx_port_vfid,
  output logic tx_ready,
  output logic rx_valid,
  output msg_kind_type rx_kind,
  output logic [`TID_W-1:0] rx_tid,
  output logic rx_tagged,
  output logic [11:0] rx_tag_vfid,
  output logic [1:0] rx_admin,
  output logic [11:0] rx_port_vfid,
  output logic [N_VF*12-1:0] rx_list
);
  logic [`TID_W-1:0] tid;
  logic [11:0] tag;
  logic [11:0] pid;
  // One message for one cycle; afterwards tid and port id are scrambled so stale values never match
  task automatic send(input msg_kind_type k, input logic [11:0] t);
    rx_valid <= 1'b1;
    rx_kind <= k;
    rx_tid <= tid;
    rx_tag_vfid <= t;
    rx_port_vfid <= peer_pid;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_tid <= ~tid;
    rx_port_vfid <= ~peer_pid;
  endtask
  // Our framer takes messages unless told to stall
  always @(posedge pclk) begin
    tx_ready <= !stall;
  end
  // Responder role: accept with the tag the sync carried, then commit tagged with the initiator port identifier
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_kind = MSG_RJT;
    rx_tid = '0;
    rx_tagged = 1'b1;
    rx_tag_vfid = 12'h000;
    rx_admin = 2'h1;
    rx_port_vfid = 12'h000;
    rx_list = '0;
    forever begin
      @(posedge pclk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_kind === MSG_SYNC) begin
        tid = tx_tid;
        tag = tx_tag_vfid;
        pid = tx_port_vfid;
        repeat (delay) @(posedge pclk);
        send(MSG_ACC, tag);
        if (do_commit) begin
          repeat (delay) @(posedge pclk);
          send(MSG_COMMIT, pid);
        end
      end
    end
  end
endmodule // evfp_peer_model

// >>> evfp_tagging_negotiation_test.sv
// Self-checking bench for the tagging negotiator in the initiator role
`timescale 1ns/1ns
`include "evfp_defines.svh"
module evfp_tagging_negotiation_test
  import evfp_pkg::*;
;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr, tx_tag_vfid, tx_port_vfid, rx_tag_vfid, rx_port_vfid, tag_pid_vfid, peer_pid;
  logic [31:0] pwdata, prdata, rd;
  logic tx_valid, tx_ready, tx_tagged, rx_valid, rx_tagged, rx_ctrl, dec_adopt, stall, do_commit;
  logic rx_tag_accept, tag_ctrl_en, tag_pid_en, go_login, isolated, success, ta_seen, iso_q;
  msg_kind_type tx_kind, rx_kind;
  logic [7:0] tx_tid, rx_tid, sync_tid, acc_tid, prev_tid;
  logic [11:0] sync_tag, acc_tag;
  logic [1:0] rx_admin;
  logic [47:0] rx_list;
  logic [3:0] dec_oper, tag_vf_en, vf_login_start, vf_seen, delay;
  int n_fail, tests_run, n_end, n_ctrl, n_login;
  evfp_tagging_negotiation #(.N_VF(4)) evfp_tagging_negotiation_i (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_name(64'h0123456789ABCDEF), .tx_valid,
    .tx_ready, .tx_kind, .tx_tid, .tx_tagged, .tx_tag_vfid, .tx_name(), .tx_admin(), .tx_port_vfid,
    .tx_list(), .tx_reason(), .rx_valid, .rx_kind, .rx_tid, .rx_tagged, .rx_tag_vfid, .rx_admin,
    .rx_port_vfid, .rx_list, .rx_ctrl, .peer_admin(), .peer_port_vfid(), .peer_list(), .dec_adopt,
    .dec_oper, .rx_tag_accept, .tag_ctrl_en, .tag_vf_en, .tag_pid_en, .tag_pid_vfid, .go_login,
    .isolated, .vf_login_start, .success);
  evfp_peer_model #(.N_VF(4)) evfp_peer_model_i (.pclk, .stall, .delay, .do_commit, .peer_pid, .tx_valid,
    .tx_kind, .tx_tid, .tx_tag_vfid, .tx_port_vfid, .tx_ready, .rx_valid, .rx_kind, .rx_tid, .rx_tagged,
    .rx_tag_vfid, .rx_admin, .rx_port_vfid, .rx_list);
  // Clock of 8 ns
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Records messages and outcomes as they pass
  always @(posedge pclk) begin
    iso_q <= isolated;
    if (go_login === 1'b1 || success === 1'b1 || (isolated === 1'b1 && iso_q !== 1'b1)) n_end <= n_end + 1;
    if (go_login === 1'b1) n_login <= n_login + 1;
    if (rx_ctrl === 1'b1) n_ctrl <= n_ctrl + 1;
    if (rx_tag_accept === 1'b1) ta_seen <= 1'b1;
    if (vf_login_start !== 4'h0) vf_seen <= vf_seen | vf_login_start;
    if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_kind === MSG_SYNC) sync_tag <= tx_tag_vfid;
    if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_kind === MSG_SYNC) sync_tid <= tx_tid;
    if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_kind === MSG_ACC) acc_tag <= tx_tag_vfid;
    if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_kind === MSG_ACC) acc_tid <= tx_tid;
  end
  task automatic test_done();
    $display("Counts: mismatches=%0d comparisons=%0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Kicks a negotiation by a register write and waits for its outcome
  task automatic run(input logic [11:0] a, input logic [31:0] d, input logic [11:0] pp, input logic ad,
                     input logic [3:0] op, input logic [3:0] dl, input logic st);
    int n;
    int e;
    peer_pid <= pp;
    dec_adopt <= ad;
    do_commit <= ad;
    dec_oper <= op;
    delay <= dl;
    stall <= st;
    ta_seen = 1'b0;
    vf_seen = 4'h0;
    prev_tid = sync_tid;
    e = n_end;
    n = 0;
    apb(1'b1, a, d);
    while (n_end == e && n < 300) begin
      @(posedge pclk);
      n++;
    end
    repeat (2) @(posedge pclk);
    chk(32'(n < 300), 32'h1);
    chk(32'(sync_tid !== prev_tid), 32'h1);
    chk(32'(ta_seen), 32'h1);
  endtask
  initial begin
    ce = 1'b1;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    dec_adopt = 1'b0;
    dec_oper = 4'h0;
    peer_pid = 12'h001;
    delay = 4'h1;
    stall = 1'b0;
    do_commit = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rd, 32'h8);
    apb(1'b0, `OFS_PORT, 32'h0);
    chk(rd, 32'h001);
    apb(1'b0, 12'h0FC, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    // Untagged outcome with equal port identifiers goes back to login
    run(`OFS_CTRL, 32'h9, 12'h001, 1'b0, 4'h0, 4'h3, 1'b0);
    chk(32'(sync_tag), 32'h001);
    chk({n_login[29:0], isolated, rx_tag_accept}, 32'h4);
    // Unequal identifiers isolate the port, which then stays quiet
    run(`OFS_CTRL, 32'h9, 12'h0AB, 1'b0, 4'h0, 4'h1, 1'b0);
    repeat (20) @(posedge pclk);
    chk({n_login[29:0], isolated, tx_valid}, 32'h6);
    // Reconfiguring the port identifier reruns it and tagging is adopted
    run(`OFS_PORT, 32'h0AB, 12'h0AB, 1'b1, 4'h6, 4'h2, 1'b0);
    chk(32'(sync_tag), 32'h0AB);
    chk({isolated, tag_ctrl_en, tag_pid_en, tag_vf_en, vf_seen}, 32'h066 | 32'h200);
    chk({acc_tag, acc_tid}, {12'h0AB, sync_tid});
    // On a tagging link the next run uses the control identifier; empty set starts no login
    n_ctrl = 0;
    run(`OFS_CTRL, 32'h9, 12'h0AB, 1'b1, 4'h0, 4'h4, 1'b0);
    chk(32'(sync_tag), 32'(`CTRL_VFID));
    chk(32'(n_ctrl > 0), 32'h1);
    chk({tag_ctrl_en, vf_seen}, 32'h10);
    test_done();
  end
  // Cuts a hung run short
  initial begin
    #(8 * 5000);
    n_fail++;
    test_done();
  end
endmodule // evfp_tagging_negotiation_test
